/* hw/epl_loader.sv */
// Behaviour
// - Ignore serial bytes while busy is high.
// - Bytes are taken only while select is low; MISO shifts on every host clock.
// - Response data returns on MISO, host clock.
// - Frame: 96 lines, 128 pixels, 1536 bytes.
`timescale 1ns/1ps
`include "epl_defines.svh"

module epl_loader #(
    parameter int unsigned UPDATE_CYC = `EPL_UPDATE_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               serial_clock_in,
    input  wire logic               panel_select_n,
    input  wire logic               mosi,
    output logic                    miso,
    output logic                    busy,
    output logic                    pix_valid,
    output epl_pkg::epl_pix_byte_t  pix_out,
    output logic                    frame_done
);
    import epl_pkg::*;

    // ----------------------------------------------------------------
    // Link domain: shift register on the host clock
    // ----------------------------------------------------------------
    // Select high acts as an asynchronous reset of the bit counter, so a
    // frame that ends mid-byte cannot leave stale bits for the next one.
    logic [7:0] sh_reg, sh_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] byte_reg, byte_next;
    logic       tog_reg, tog_next;
    logic [7:0] tx_reg, tx_next;
    logic       miso_reg;
    logic [1:0] busy_l_sync;

    always_comb begin
        sh_next   = {sh_reg[6:0], mosi};
        bit_next  = bit_reg + 3'h1;
        byte_next = byte_reg;
        tog_next  = tog_reg;
        tx_next   = {tx_reg[6:0], 1'b0};
        if (bit_reg == `EPL_LAST_BIT) begin
            tx_next = busy_l_sync[1] ? `EPL_STAT_BUSY : `EPL_STAT_READY;
            if (!panel_select_n) begin
                byte_next = {sh_reg[6:0], mosi};
                tog_next  = ~tog_reg;
            end
        end
    end

    always_ff @(posedge serial_clock_in or posedge panel_select_n) begin
        if (panel_select_n) begin
            sh_reg  <= 8'h00;
            bit_reg <= 3'h0;
        end else begin
            sh_reg  <= sh_next;
            bit_reg <= bit_next;
        end
    end

    always_ff @(posedge serial_clock_in or posedge rst) begin
        if (rst) begin
            byte_reg    <= 8'h00;
            tog_reg     <= 1'b0;
            busy_l_sync <= 2'b00;
        end else begin
            busy_l_sync <= {busy_l_sync[0], busy};
            byte_reg    <= byte_next;
            tog_reg     <= tog_next;
        end
    end

    // Response shifts out on the falling edge so the host samples it stably.
    always_ff @(negedge serial_clock_in or posedge rst) begin
        if (rst) begin
            tx_reg   <= `EPL_MISO_IDLE;
            miso_reg <= 1'b0;
        end else begin
            tx_reg   <= tx_next;
            miso_reg <= tx_reg[7];
        end
    end

    // ----------------------------------------------------------------
    // System domain: byte capture and frame sequencing
    // ----------------------------------------------------------------
    logic [2:0]     tog_sync;
    logic           byte_evt;
    epl_state_t     st_reg, st_next;
    logic [10:0]    idx_reg, idx_next;
    logic [`EPL_CNT_W-1:0] cnt_reg, cnt_next;
    logic           pv_reg, pv_next;
    epl_pix_byte_t  px_reg, px_next;
    logic           fd_reg, fd_next;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) tog_sync <= 3'b000;
        else     tog_sync <= {tog_sync[1:0], tog_reg};
    end
    // The byte register is stable for eight host clocks after the toggle,
    // far longer than the synchroniser delay, so it is read directly.
    assign byte_evt = tog_sync[2] ^ tog_sync[1];

    always_comb begin
        st_next  = st_reg;
        idx_next = idx_reg;
        cnt_next = cnt_reg;
        pv_next  = 1'b0;
        px_next  = px_reg;
        fd_next  = 1'b0;
        unique case (st_reg)
            EPL_IDLE, EPL_LOAD: begin
                if (byte_evt) begin
                    pv_next       = 1'b1;
                    px_next.index = idx_reg;
                    px_next.data  = byte_reg;
                    st_next       = EPL_LOAD;
                    if (idx_reg == `EPL_LAST_BYTE) begin
                        idx_next = 11'h000;
                        cnt_next = '0;
                        st_next  = EPL_UPDATE;
                    end else begin
                        idx_next = idx_reg + 11'h001;
                    end
                end
            end
            EPL_UPDATE: begin
                // Byte events are not looked at here, so a byte that the host
                // sends during the update is dropped without a trace.
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == `EPL_CNT_W'(UPDATE_CYC - 1)) begin
                    st_next = EPL_IDLE;
                    fd_next = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg     <= EPL_IDLE;
            idx_reg    <= 11'h000;
            cnt_reg    <= '0;
            pv_reg     <= 1'b0;
            px_reg     <= '0;
            fd_reg     <= 1'b0;
        end else begin
            st_reg     <= st_next;
            idx_reg    <= idx_next;
            cnt_reg    <= cnt_next;
            pv_reg     <= pv_next;
            px_reg     <= px_next;
            fd_reg     <= fd_next;
        end
    end

    logic busy_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) busy_reg <= 1'b0;
        else     busy_reg <= (st_next == EPL_UPDATE);
    end

    assign miso       = miso_reg;
    assign busy       = busy_reg;
    assign pix_valid  = pv_reg;
    assign pix_out    = px_reg;
    assign frame_done = fd_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // An index model kept apart from the sequencer counts the accepted bytes,
    // so a fault in the sequencer's own counter cannot hide from the check.
    logic [10:0] chk_idx_reg, chk_idx_next;

    always_comb begin
        chk_idx_next = chk_idx_reg;
        if (pix_valid) begin
            if (chk_idx_reg == `EPL_LAST_BYTE) chk_idx_next = 11'h000;
            else                              chk_idx_next = chk_idx_reg + 11'h001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) chk_idx_reg <= 11'h000;
        else     chk_idx_reg <= chk_idx_next;
    end

    a_busy_no_pix: assert property (@(posedge clk_sys) disable iff (rst)
        busy && $past(busy) |-> !pix_valid)
        else $error("pixel byte accepted while busy");

    a_last_starts_busy: assert property (@(posedge clk_sys) disable iff (rst)
        pix_valid && pix_out.index == `EPL_LAST_BYTE |-> busy)
        else $error("busy not raised after last frame byte");

    a_index_steps: assert property (@(posedge clk_sys) disable iff (rst)
        pix_valid |-> pix_out.index == chk_idx_reg)
        else $error("index sequence broken");

    a_pix_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        pix_valid |=> !pix_valid)
        else $error("pixel valid longer than one cycle");

    a_done_ends_busy: assert property (@(posedge clk_sys) disable iff (rst)
        frame_done |-> !busy && $past(busy))
        else $error("frame done without busy falling");

    a_busy_after_last: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(busy) |-> pix_valid && pix_out.index == `EPL_LAST_BYTE)
        else $error("busy raised without last frame byte");

    a_select_clears_bits: assert property (@(posedge serial_clock_in) disable iff (rst)
        panel_select_n |=> bit_reg == 3'h0)
        else $error("bit counter not cleared by select");
endmodule : epl_loader

/* hw/epl_defines.svh */
`ifndef EPL_DEFINES_SVH
`define EPL_DEFINES_SVH

`define EPL_PIX_PER_LINE     8'h80
`define EPL_LINES            7'h60
`define EPL_FRAME_BYTES      11'h600
`define EPL_LAST_BYTE        11'h5FF
`define EPL_LAST_BIT         3'h7
`define EPL_MISO_IDLE        8'h00
`define EPL_STAT_READY       8'hA5
`define EPL_STAT_BUSY        8'h5A
// Panel update time in microseconds and its cycle count at the system clock.
`define EPL_UPDATE_US        1000000
`define EPL_CLK_MHZ          100
`define EPL_UPDATE_CYC       (`EPL_UPDATE_US * `EPL_CLK_MHZ)
`define EPL_CNT_W            27

`endif

/* hw/epl_pkg.sv */
package epl_pkg;
    typedef struct packed {
        logic [10:0] index;
        logic [7:0]  data;
    } epl_pix_byte_t;

    typedef struct packed {
        logic        busy;
        logic        frame_done;
    } epl_status_t;

    typedef enum logic [1:0] {
        EPL_IDLE,
        EPL_LOAD,
        EPL_UPDATE
    } epl_state_t;
endpackage : epl_pkg

/* test/epl_host_model.sv */
`timescale 1ns/1ps

module epl_host_model (
    output logic      serial_clock_in,
    output logic      panel_select_n,
    output logic      mosi,
    input  wire logic miso
);
    logic [7:0] resp_reg;

    // The clock stands low outside frames, and a released data line shows the
    // inverse of its last value so that a stale bit is never read as good data.
    initial begin
        serial_clock_in = 1'b0;
        panel_select_n  = 1'b1;
        mosi            = 1'b0;
        resp_reg        = 8'h00;
    end

    task automatic select(input logic on);
        #160 panel_select_n = ~on;
        if (!on) begin
            mosi = ~mosi;
        end
        #160;
    endtask : select

    // Data changes while the clock is low, half a period ahead of the rising
    // edge, and the response is sampled on that same rising edge.
    task automatic send_bits(input logic [7:0] b, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            mosi = b[7-i];
            #80 serial_clock_in = 1'b1;
            resp_reg = {resp_reg[6:0], miso};
            #80 serial_clock_in = 1'b0;
        end
    endtask : send_bits
endmodule : epl_host_model

/* test/epl_loader_tb_top.sv */
`timescale 1ns/1ps

module epl_loader_tb_top;
    import epl_pkg::*;
    localparam int unsigned UPD = 600;
    logic             clk_sys;
    logic             rst;
    logic             sck;
    logic             sel_n;
    logic             mosi;
    logic             miso;
    logic             busy;
    logic             pix_valid;
    epl_pix_byte_t    pix_out;
    logic             frame_done;
    int               n_mismatch;
    int               check_count;
    int               n_seen;
    logic             done_seen;

    epl_loader #(.UPDATE_CYC(UPD)) epl_loader_i (.clk_sys(clk_sys), .rst(rst), .serial_clock_in(sck),
        .panel_select_n(sel_n), .mosi(mosi), .miso(miso), .busy(busy), .pix_valid(pix_valid),
        .pix_out(pix_out), .frame_done(frame_done));
    epl_host_model epl_host_model_i (.serial_clock_in(sck), .panel_select_n(sel_n), .mosi(mosi),
        .miso(miso));

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 7 + 8'h3C);
    endfunction : pat

    task automatic check(input logic [18:0] got, input logic [18:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (pix_valid === 1'b1) begin
            check(pix_out, {11'(n_seen % 1536), pat(n_seen % 1536)}, "pixel byte");
            n_seen++;
        end
        if (frame_done === 1'b1) begin
            done_seen = 1'b1;
        end
    end

    task automatic t_no_select;
        epl_host_model_i.send_bits(8'hC3, 8);
        epl_host_model_i.select(1'b1);
        epl_host_model_i.send_bits(8'h81, 5);
        epl_host_model_i.select(1'b0);
        repeat (20) @(posedge clk_sys);
        check(19'(n_seen), 19'h00000, "bytes without select or whole byte");
        $display("t_no_select done");
    endtask : t_no_select

    task automatic t_frame;
        epl_host_model_i.select(1'b1);
        for (int i = 0; i < 1536; i++) begin
            epl_host_model_i.send_bits(pat(i), 8);
            if (i == 1) check(19'(epl_host_model_i.resp_reg), 19'h000A5, "ready reply");
        end
        epl_host_model_i.select(1'b0);
        check(19'(n_seen), 19'h00600, "frame byte count");
        check(19'(busy), 19'h00001, "busy after frame");
        $display("t_frame done");
    endtask : t_frame

    task automatic t_busy_drop;
        int n;
        epl_host_model_i.select(1'b1);
        epl_host_model_i.send_bits(8'hFF, 8);
        epl_host_model_i.send_bits(8'h00, 8);
        check(19'(epl_host_model_i.resp_reg), 19'h0005A, "busy reply");
        epl_host_model_i.select(1'b0);
        for (n = 0; n < UPD + 100 && busy !== 1'b0; n++) @(posedge clk_sys);
        @(posedge clk_sys);
        check(19'(n_seen), 19'h00600, "bytes dropped while busy");
        check(19'({busy, done_seen}), 19'h00001, "update ended");
        epl_host_model_i.select(1'b1);
        epl_host_model_i.send_bits(pat(0), 8);
        epl_host_model_i.select(1'b0);
        check(19'(n_seen), 19'h00601, "new frame restarts at index 0");
        $display("t_busy_drop done");
    endtask : t_busy_drop

    task automatic t_reset_mid;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        n_seen = 0;
        repeat (4) @(posedge clk_sys);
        check(19'({busy, pix_valid, frame_done}), 19'h00000, "outputs after reset");
        epl_host_model_i.select(1'b1);
        epl_host_model_i.send_bits(pat(0), 8);
        epl_host_model_i.select(1'b0);
        check(19'(n_seen), 19'h00001, "index restarts after reset");
        $display("t_reset_mid done");
    endtask : t_reset_mid

    initial begin
        #5000000;
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        n_mismatch = 0;
        check_count = 0;
        n_seen = 0;
        done_seen = 1'b0;
        rst = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (50) @(posedge clk_sys);
        #3;
        t_no_select();
        t_frame();
        t_busy_drop();
        t_reset_mid();
        final_report();
    end
endmodule : epl_loader_tb_top
